// ---- core/gpt_map.svh ----
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH
// Register byte offsets, one aligned word each
`define GPT_A_CTRL_OFF    12'h000
`define GPT_A_COUNT_OFF   12'h010
`define GPT_A_PERIOD_OFF  12'h020
`define GPT_B0_CTRL_OFF   12'h040
`define GPT_B0_COUNT_OFF  12'h050
`define GPT_B0_PERIOD_OFF 12'h060
`define GPT_B1_CTRL_OFF   12'h080
`define GPT_B1_COUNT_OFF  12'h090
`define GPT_B1_PERIOD_OFF 12'h0a0
`define GPT_IRQ_EN_OFF    12'h0c0
`define GPT_IRQ_FLAG_OFF  12'h0d0
`define GPT_IRQ_PRIO_OFF  12'h0e0
// Control field positions
`define GPT_ON_BIT        15
`define GPT_IDLE_BIT      13
`define GPT_WBLK_BIT      12
`define GPT_WPEND_BIT     11
`define GPT_GATE_BIT      7
`define GPT_PS_HI         6
`define GPT_PS_LO         4
`define GPT_A_PS_HI       5
`define GPT_JOIN_BIT      3
`define GPT_SYNC_BIT      2
`define GPT_CS_BIT        1
// Masks of implemented control bits
`define GPT_A_CTRL_MASK   16'hb0b6
`define GPT_B0_CTRL_MASK  16'ha0fa
`define GPT_B1_CTRL_MASK  16'ha0f2
// Reset values
`define GPT_RST_PERIOD    16'hffff
`define GPT_RST_ZERO      16'h0000
`endif

// ---- core/gpt_pkg.sv ----
package gpt_pkg;
    typedef logic [15:0] gpt_word_t;
    typedef enum logic [1:0] {GPT_WR_IDLE, GPT_WR_SYNC, GPT_WR_APPLY} gpt_wr_e;
endpackage : gpt_pkg

// ---- core/gpt_timer_pair.sv ----
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "gpt_map.svh"
// What this block does
// - Variant A prescales its count input by 1, 8, 64 or 256.
// - Variant B prescales by 1, 2, 4, 8, 16, 32, 64 or 256.
// - Variant A is strictly 16-bit and never joins another timer.
// - Only even B timer joins with next odd timer for 32 bits.
// - Joined mode: even control governs counting, odd owns interrupt.
// - Variant A counts external clock unsynchronised or secondary oscillator.
// - Variant A keeps counting in sleep from an asynchronous source.
// - Even B timer, or the joined pair, drives converter event trigger; variant A has none.
// - Gated mode counts internal clocks only while the gate is active.
// - Clock source bit picks internal or external; B syncs external.
// - Variant A control bit layout: 15,13,12,11,7,5:4,2,1.
// - Variant B control bit layout: 15,13,7,6:4,3,1.
// - Count and period are 16 bits in low half of word.
// - Each timer has irq enable, flag, 3-bit priority, 2-bit subpriority.
// - Variant A prescale code 00,01,10,11 gives 1,8,64,256.
// - Timer counts only while its enable bit is one.
// - Gate bit is ignored while external clock is selected.
// - Write block makes count writes ignored while async write pends.
module gpt_timer_pair
    import gpt_pkg::*;
(
    input  wire logic        clk_in,          // Peripheral clock, 100 MHz
    input  wire logic        rstn_in,         // Async reset, active low
    input  wire logic        psel_in,         // APB select
    input  wire logic        penable_in,      // APB enable
    input  wire logic        pwrite_in,       // APB write
    input  wire logic [11:0] paddr_in,        // APB byte address
    input  wire logic [31:0] pwdata_in,       // APB write data
    output logic      [31:0] prdata_out,      // APB read data
    output logic             pready_out,      // APB ready
    output logic             pslverr_out,     // APB error, unmapped address
    input  wire logic        a_ext_clk_in,    // Variant A external or oscillator clock
    input  wire logic        b0_ext_in,       // Even B external count input
    input  wire logic        b1_ext_in,       // Odd B external count input
    input  wire logic [2:0]  gate_in,         // Gate inputs A, B0, B1, active high
    input  wire logic        idle_in,         // Device idle mode
    output logic             a_irq_out,       // Variant A interrupt request
    output logic             b0_irq_out,      // Even B interrupt request
    output logic             b1_irq_out,      // Odd B interrupt request
    output logic             adc_trig_out     // Converter event trigger pulse
);
    // Bus decode
    wire       acc      = psel_in & penable_in;
    wire       wr       = acc & pwrite_in;
    wire [11:0] a       = paddr_in;
    wire       hit_ac   = a == `GPT_A_CTRL_OFF;
    wire       hit_acn  = a == `GPT_A_COUNT_OFF;
    wire       hit_ap   = a == `GPT_A_PERIOD_OFF;
    wire       hit_c0   = a == `GPT_B0_CTRL_OFF;
    wire       hit_n0   = a == `GPT_B0_COUNT_OFF;
    wire       hit_p0   = a == `GPT_B0_PERIOD_OFF;
    wire       hit_c1   = a == `GPT_B1_CTRL_OFF;
    wire       hit_n1   = a == `GPT_B1_COUNT_OFF;
    wire       hit_p1   = a == `GPT_B1_PERIOD_OFF;
    wire       hit_ie   = a == `GPT_IRQ_EN_OFF;
    wire       hit_if   = a == `GPT_IRQ_FLAG_OFF;
    wire       hit_ip   = a == `GPT_IRQ_PRIO_OFF;
    wire       mapped   = hit_ac | hit_acn | hit_ap | hit_c0 | hit_n0 | hit_p0 | hit_c1
                        | hit_n1 | hit_p1 | hit_ie | hit_if | hit_ip;
    // Holes answer with an error and read as zero,
    // so a stray access never disturbs a running timer

    // Register state; count and period keep the low half only
    gpt_word_t a_ctrl_reg, a_cnt_reg, a_per_reg;
    gpt_word_t c0_reg, n0_reg, p0_reg, c1_reg, n1_reg, p1_reg;
    logic [2:0]  ie_reg, if_reg;
    logic [14:0] ip_reg;                        // Three fields of priority 3 bits, sub 2 bits
    gpt_wr_e     wst_reg;
    gpt_word_t   wdata_reg;


    // Variant A: no join bit, no trigger, always 16-bit
    // Block bit matters only while a count load is in flight
    wire a_on    = a_ctrl_reg[`GPT_ON_BIT];
    wire a_cs    = a_ctrl_reg[`GPT_CS_BIT];
    wire a_async = a_cs & ~a_ctrl_reg[`GPT_SYNC_BIT];
    wire a_run   = a_on & (a_async | ~(idle_in & a_ctrl_reg[`GPT_IDLE_BIT]));
    wire a_pend  = wst_reg != GPT_WR_IDLE;
    wire a_wok   = ~(a_ctrl_reg[`GPT_WBLK_BIT] & a_pend);


    // Edge detect on external inputs; the last stage feeds comparators
    // Both stages reset low, the idle pin level,
    // so release of reset never shows a false edge
    logic [2:0] ext_d_reg, ext_q_reg;
    wire  [2:0] ext_rise = ext_d_reg & ~ext_q_reg;

    // Variant A asynchronous count domain: ripple count kept in the clk_in domain
    // for determinism; the asynchronous path is modelled as unsynchronised edges
    // of a_ext_clk_in, which costs metastability margin but no extra cycles.
    logic a_ext_q_reg;
    wire  a_ext_edge = a_async ? (a_ext_clk_in & ~a_ext_q_reg) : ext_rise[0];

    // Tick sources per timer, gate ignored when external chosen
    wire b0_cs = c0_reg[`GPT_CS_BIT];
    wire b1_cs = c1_reg[`GPT_CS_BIT];
    // Only the even control has a join bit; the odd mask drops it
    wire pair_on = c0_reg[`GPT_JOIN_BIT];

    // In joined mode the even control steers both halves
    // Odd control keeps its value, so leaving joined mode
    // hands the odd timer back its own settings
    wire [15:0] c1_eff = pair_on ? c0_reg : c1_reg;

    logic [2:0] src_tick;
    always_comb begin
        // Gated accumulation only for internal clock
        src_tick[0] = a_cs ? a_ext_edge
                    : (~a_ctrl_reg[`GPT_GATE_BIT] | gate_in[0]);
        src_tick[1] = b0_cs ? ext_rise[1]
                    : (~c0_reg[`GPT_GATE_BIT] | gate_in[1]);
        // Joined: odd half follows the even pin and gate
        src_tick[2] = c1_eff[`GPT_CS_BIT] ? (pair_on ? ext_rise[1] : ext_rise[2])
                    : (~c1_eff[`GPT_GATE_BIT] | (pair_on ? gate_in[1] : gate_in[2]));
    end

    wire b0_run = c0_reg[`GPT_ON_BIT] & ~(idle_in & c0_reg[`GPT_IDLE_BIT]);
    wire b1_run = c1_eff[`GPT_ON_BIT] & ~(idle_in & c1_eff[`GPT_IDLE_BIT]);
    wire [2:0] run = {b1_run, b0_run, a_run};

    // Limit is the divide ratio minus one
    // Prescaler holds at zero while stopped,
    // so a restart always begins a full period
    // Trade-off: a running ratio change takes effect mid-period


    // Prescale limits: A codes 1,8,64,256; B codes 1..64 by powers of two, then 256
    logic [7:0] lim [3];
    always_comb begin
        case (a_ctrl_reg[`GPT_A_PS_HI:`GPT_PS_LO])
            2'h0:    lim[0] = 8'h00;
            2'h1:    lim[0] = 8'h07;
            2'h2:    lim[0] = 8'h3f;
            default: lim[0] = 8'hff;
        endcase
        lim[1] = (c0_reg[`GPT_PS_HI:`GPT_PS_LO] == 3'h7) ? 8'hff
               : 8'((9'h001 << c0_reg[`GPT_PS_HI:`GPT_PS_LO]) - 9'h001);
        lim[2] = (c1_eff[`GPT_PS_HI:`GPT_PS_LO] == 3'h7) ? 8'hff
               : 8'((9'h001 << c1_eff[`GPT_PS_HI:`GPT_PS_LO]) - 9'h001);
    end

    // One prescaler per timer
    logic [7:0] ps_reg [3];
    logic [2:0] tick;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ps
            assign tick[g] = run[g] & src_tick[g] & (ps_reg[g] >= lim[g]);
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in)
                    ps_reg[g] <= 8'h00;
                else if (!run[g])
                    ps_reg[g] <= 8'h00;
                else if (src_tick[g])
                    ps_reg[g] <= tick[g] ? 8'h00 : ps_reg[g] + 8'h01;
            end
        end
    endgenerate

    // Count next values and matches
    // Match uses the count before the tick, so period N
    // gives N + 1 counts per wrap; period zero wraps every tick

    wire        a_match  = a_cnt_reg == a_per_reg;
    wire [31:0] cnt32    = {n1_reg, n0_reg};
    wire [31:0] per32    = {p1_reg, p0_reg};
    wire        m32      = cnt32 == per32;
    wire        m0       = n0_reg == p0_reg;
    wire        m1       = n1_reg == p1_reg;
    wire        j_tick   = pair_on & tick[1];
    wire [31:0] cnt32_nx = m32 ? 32'h0 : cnt32 + 32'h1;

    // Match events; joined mode reports through the odd slot only
    wire [2:0]  ev       = {pair_on ? j_tick & m32 : tick[2] & m1,
                            ~pair_on & tick[1] & m0,
                            tick[0] & a_match};
    wire [31:0] rd_ctrl_a = {16'h0, a_ctrl_reg | (a_pend ? 16'h0800 : 16'h0)};


    // Read mux
    // One-hot select; unmapped addresses fall to zero
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0;
        case (1'b1)
            hit_ac:  rd = rd_ctrl_a;
            hit_acn: rd = {16'h0, a_cnt_reg};
            hit_ap:  rd = {16'h0, a_per_reg};
            hit_c0:  rd = {16'h0, c0_reg};
            hit_n0:  rd = {16'h0, n0_reg};
            hit_p0:  rd = {16'h0, p0_reg};
            hit_c1:  rd = {16'h0, c1_reg};
            hit_n1:  rd = {16'h0, n1_reg};
            hit_p1:  rd = {16'h0, p1_reg};
            hit_ie:  rd = {29'h0, ie_reg};
            hit_if:  rd = {29'h0, if_reg};
            hit_ip:  rd = {17'h0, ip_reg};
            default: rd = 32'h0;
        endcase
    end


    // APB answer: zero wait states, registered outputs
    // Ready rises in the access cycle and drops after it,
    // so a back-to-back setup is seen cleanly
    // Read data registered at setup; address must hold to access
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_out  <= 32'h0;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= psel_in & ~penable_in & ~pready_out;
            pslverr_out <= psel_in & ~penable_in & ~pready_out & ~mapped;
            prdata_out  <= rd;
        end
    end

    // A write lands only at the edge closing the access cycle
    wire take = wr & pready_out & mapped;


    // Control and period registers
    // Pending bit is read-only, so the write mask clears it
    // Unused bits never store, so they always read as zero
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            a_ctrl_reg <= `GPT_RST_ZERO;
            c0_reg     <= `GPT_RST_ZERO;
            c1_reg     <= `GPT_RST_ZERO;
            a_per_reg  <= `GPT_RST_PERIOD;
            p0_reg     <= `GPT_RST_PERIOD;
            p1_reg     <= `GPT_RST_PERIOD;
            ie_reg     <= 3'h0;
            ip_reg     <= 15'h0;
        end else if (take) begin
            if (hit_ac) a_ctrl_reg <= pwdata_in[15:0] & `GPT_A_CTRL_MASK & 16'hf7ff;
            if (hit_c0) c0_reg     <= pwdata_in[15:0] & `GPT_B0_CTRL_MASK;
            if (hit_c1) c1_reg     <= pwdata_in[15:0] & `GPT_B1_CTRL_MASK;
            if (hit_ap) a_per_reg  <= pwdata_in[15:0];
            if (hit_p0) p0_reg     <= pwdata_in[15:0];
            if (hit_p1) p1_reg     <= pwdata_in[15:0];
            if (hit_ie) ie_reg     <= pwdata_in[2:0];
            if (hit_ip) ip_reg     <= pwdata_in[14:0];
        end
    end


    // Variant A count write passes a short pending phase, visible as pending bit
    // Async source adds a sync stage before the load
    // A second write in that stage replaces the data
    // unless the block bit is set
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wst_reg   <= GPT_WR_IDLE;
            wdata_reg <= `GPT_RST_ZERO;
        end else begin
            case (wst_reg)
                GPT_WR_IDLE:  if (take && hit_acn) begin
                    wdata_reg <= pwdata_in[15:0];
                    wst_reg   <= a_async ? GPT_WR_SYNC : GPT_WR_APPLY;
                end
                GPT_WR_SYNC:  begin
                    if (take && hit_acn && a_wok) wdata_reg <= pwdata_in[15:0];
                    wst_reg <= GPT_WR_APPLY;
                end
                GPT_WR_APPLY: wst_reg <= GPT_WR_IDLE;
                default:      wst_reg <= GPT_WR_IDLE;
            endcase
        end
    end


    // Counters, edge history
    // A register write wins over a tick in the same cycle
    // Joined mode moves both halves on the even tick only
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            a_cnt_reg   <= `GPT_RST_ZERO;
            n0_reg      <= `GPT_RST_ZERO;
            n1_reg      <= `GPT_RST_ZERO;
            ext_d_reg   <= 3'h0;
            ext_q_reg   <= 3'h0;
            a_ext_q_reg <= 1'b0;
        end else begin
            ext_d_reg   <= {b1_ext_in, b0_ext_in, a_ext_clk_in};
            ext_q_reg   <= ext_d_reg;
            a_ext_q_reg <= a_ext_clk_in;
            if (wst_reg == GPT_WR_APPLY)
                a_cnt_reg <= wdata_reg;
            else if (tick[0])
                a_cnt_reg <= a_match ? 16'h0 : a_cnt_reg + 16'h1;
            if (take && hit_n0)
                n0_reg <= pwdata_in[15:0];
            else if (j_tick)
                n0_reg <= cnt32_nx[15:0];
            else if (!pair_on && tick[1])
                n0_reg <= m0 ? 16'h0 : n0_reg + 16'h1;
            if (take && hit_n1)
                n1_reg <= pwdata_in[15:0];
            else if (j_tick)
                n1_reg <= cnt32_nx[31:16];
            else if (!pair_on && tick[2])
                n1_reg <= m1 ? 16'h0 : n1_reg + 16'h1;
        end
    end


    // Flags: hardware set wins over software clear-by-one
    // Irq lines from flops: rise with a match flag, follow clears and enable one cycle late
    // Event is folded in so a new match is never lost
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            if_reg       <= 3'h0;
            a_irq_out    <= 1'b0;
            b0_irq_out   <= 1'b0;
            b1_irq_out   <= 1'b0;
            adc_trig_out <= 1'b0;
        end else begin
            if_reg       <= (if_reg & ~((take && hit_if) ? pwdata_in[2:0] : 3'h0)) | ev;
            a_irq_out    <= (if_reg[0] | ev[0]) & ie_reg[0];
            b0_irq_out   <= (if_reg[1] | ev[1]) & ie_reg[1];
            b1_irq_out   <= (if_reg[2] | ev[2]) & ie_reg[2];
            adc_trig_out <= pair_on ? ev[2] : ev[1];
        end
    end
endmodule : gpt_timer_pair

// ---- verification/gpt_chk.sv ----
`timescale 1ns/10ps
`include "gpt_map.svh"
module gpt_chk (
    input wire logic        clk_in,      // Clock
    input wire logic        rstn_in,     // Reset, active low
    input wire logic        psel_in,     // Select
    input wire logic        penable_in,  // Enable
    input wire logic        pwrite_in,   // Write
    input wire logic [11:0] paddr_in,    // Address
    input wire logic [31:0] prdata_out,  // Read data
    input wire logic        pready_out,  // Ready
    input wire logic        pslverr_out, // Error
    input wire logic        b0_irq_out,  // Even timer irq
    input wire logic        adc_trig_out // Converter trigger
);
    // Decodes; slots 3, 7, 11 and 15 of the map are holes
    wire logic [3:0] slot   = paddr_in[7:4];
    wire logic       mapped = paddr_in[11:8] == 4'h0 && paddr_in[3:0] == 4'h0 && slot[1:0] != 2'h3;
    wire logic       rd_ack = pready_out && !pwrite_in;
    wire logic       clr_wr = pready_out && pwrite_in && paddr_in[11:5] == 7'h06;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_ready_setup: assert property (psel_in && !penable_in ##1 penable_in |-> pready_out)
        else $error("no ready in access cycle");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held too long");
    a_err_map: assert property (pready_out |-> pslverr_out == !mapped)
        else $error("error flag disagrees with map");
    a_err_zero: assert property (rd_ack && pslverr_out |-> prdata_out == 32'h0)
        else $error("refused read returned data");
    a_word_upper: assert property (rd_ack && slot[1:0] != 2'h0 |-> prdata_out[31:16] == 16'h0)
        else $error("upper half of count or period set");
    a_a_ctrl: assert property (rd_ack && paddr_in == `GPT_A_CTRL_OFF |-> (prdata_out & ~32'hb8b6) == 0)
        else $error("unused bit set in variant A control");
    a_b0_ctrl: assert property (rd_ack && paddr_in == `GPT_B0_CTRL_OFF |-> (prdata_out & ~32'ha0fa) == 0)
        else $error("unused bit set in even control");
    a_b1_nojoin: assert property (rd_ack && paddr_in == `GPT_B1_CTRL_OFF |-> (prdata_out & ~32'ha0f2) == 0)
        else $error("odd control shows a join bit");
    a_irq_hold: assert property ($fell(b0_irq_out) |-> $past(clr_wr, 2))
        else $error("irq dropped without a clear");
    a_trig_pulse: assert property (adc_trig_out |=> !adc_trig_out)
        else $error("trigger wider than one cycle");
    // Main scenarios reached
    c_refused: cover property (pslverr_out);
    c_irq: cover property ($rose(b0_irq_out));
    c_trig: cover property (adc_trig_out);
endmodule : gpt_chk
bind gpt_timer_pair gpt_chk gpt_chk_inst (.clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .prdata_out, .pready_out, .pslverr_out, .b0_irq_out, .adc_trig_out);

// ---- verification/gpt_src.sv ----
`timescale 1ns/10ps
// Far-side pulse source; the line rests low between bursts
module gpt_src #(
    parameter int HALF = 3 // Cycles per half period
) (
    input  wire logic        clk_in,   // Clock
    input  wire logic        rstn_in,  // Reset, active low
    input  wire logic        run_in,   // Burst request
    input  wire logic        slow_in,  // Doubles the half period
    output logic             ext_out,  // Pulse line
    output logic [15:0]      edges_out // Rising edges sent
);
    wire logic [7:0] lim = slow_in ? 8'(2 * HALF - 1) : 8'(HALF - 1);
    logic      [7:0] ph_reg;
    // Finish a high phase before resting, so no runt pulse reaches the timer
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ph_reg <= 8'h00;
            ext_out <= 1'b0;
            edges_out <= 16'h0000;
        end else if (run_in || ext_out) begin
            ph_reg <= (ph_reg >= lim) ? 8'h00 : ph_reg + 8'h01;
            if (ph_reg >= lim) begin
                ext_out <= !ext_out;
                edges_out <= edges_out + {15'h0, !ext_out};
            end
        end
    end
endmodule : gpt_src

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
`include "gpt_map.svh"
module tb_top;
    localparam logic [31:0] k_on = 32'h8000, k_gate = 32'h0080, k_cs = 32'h0002;
    localparam logic [31:0] k_join = 32'h0008, k_idle = 32'h2000;
    logic        clk_in = 1'b0, rstn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
    logic        pwrite_in = 1'b0, idle_in = 1'b0, run = 1'b0, slow = 1'b0, ext;
    logic        pready_out, pslverr_out, a_irq_out, b0_irq_out, b1_irq_out, adc_trig_out;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out;
    logic [2:0]  gate_in = 3'h0;
    logic [15:0] edges;
    int          bad_count = 0, n_checks = 0, trig_n = 0;
    gpt_timer_pair gpt_timer_pair_inst (.clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .a_ext_clk_in(ext),
        .b0_ext_in(ext), .b1_ext_in(ext), .gate_in, .idle_in, .a_irq_out, .b0_irq_out,
        .b1_irq_out, .adc_trig_out);
    gpt_src gpt_src_inst (.clk_in, .rstn_in, .run_in(run), .slow_in(slow), .ext_out(ext),
        .edges_out(edges));
    // Clock, and a tally of converter triggers
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) if (adc_trig_out === 1'b1) trig_n <= trig_n + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
        n_checks++;
        if ((got >= 32'(lo) && got <= 32'(hi)) !== 1'b1) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cyc
    // One bus transfer; an idle cycle follows so strobes never toggle twice at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 64);
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd
    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        rd(a, r);
        chk(r, x);
    endtask : rdc
    // Burst of n pulses from the far side, then let the line rest
    task automatic pulses(input int n);
        int e0;
        e0 = edges;
        run <= 1'b1;
        for (int i = 0; i < 800 && edges < 16'(e0 + n); i++) @(posedge clk_in);
        run <= 1'b0;
        cyc(20);
    endtask : pulses
    task automatic t_regs();
        logic [11:0] base [3] = '{`GPT_A_CTRL_OFF, `GPT_B0_CTRL_OFF, `GPT_B1_CTRL_OFF};
        logic [15:0] mask [3] = '{16'hb0b6, 16'ha0fa, 16'ha0f2};
        logic [31:0] r;
        logic        e;
        for (int t = 0; t < 3; t++) begin
            rdc(base[t], 32'h0);
            rdc(base[t] + 12'h010, 32'h0);
            rdc(base[t] + 12'h020, 32'hffff);
            wr(base[t], 32'hffffffff);
            rdc(base[t], {16'h0, mask[t]});
            wr(base[t], 32'h0);
        end
        apb(1'b0, 12'h0f0, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
    endtask : t_regs
    task automatic t_prescale();
        int          dv [12] = '{1, 8, 64, 256, 1, 2, 4, 8, 16, 32, 64, 256};
        logic [11:0] b;
        logic [31:0] r;
        for (int t = 0; t < 12; t++) begin
            b = (t < 4) ? `GPT_A_CTRL_OFF : `GPT_B0_CTRL_OFF;
            wr(b + 12'h010, 32'h0);
            wr(b, k_on | (32'((t < 4) ? t : t - 4) << 4));
            cyc(dv[t] * 8);
            wr(b, 32'h0);
            rd(b + 12'h010, r);
            chk_rng(r, 7, 12);
            cyc(20);
            rdc(b + 12'h010, r);
        end
    endtask : t_prescale
    task automatic t_wrap();
        int          n0;
        logic [31:0] r;
        n0 = trig_n;
        wr(`GPT_IRQ_EN_OFF, 32'h3);
        wr(`GPT_A_PERIOD_OFF, 32'h4);
        wr(`GPT_A_COUNT_OFF, 32'h0);
        wr(`GPT_A_CTRL_OFF, k_on);
        cyc(12);
        chk({31'h0, a_irq_out}, 32'h1);
        chk(32'(trig_n - n0), 32'h0);
        wr(`GPT_B0_PERIOD_OFF, 32'h4);
        wr(`GPT_B0_COUNT_OFF, 32'h0);
        wr(`GPT_B0_CTRL_OFF, k_on);
        cyc(12);
        chk({31'h0, b0_irq_out}, 32'h1);
        chk_rng(32'(trig_n - n0), 2, 4);
        wr(`GPT_A_CTRL_OFF, 32'h0);
        wr(`GPT_B0_CTRL_OFF, 32'h0);
        rd(`GPT_B0_COUNT_OFF, r);
        chk_rng(r, 0, 4);
        wr(`GPT_IRQ_FLAG_OFF, 32'h3);
        cyc(2);
        chk({29'h0, a_irq_out, b0_irq_out, b1_irq_out}, 32'h0);
    endtask : t_wrap
    task automatic t_gate_join();
        int          e0;
        logic [31:0] r;
        wr(`GPT_B0_PERIOD_OFF, 32'hffff);
        wr(`GPT_B0_COUNT_OFF, 32'h0);
        wr(`GPT_B0_CTRL_OFF, k_on | k_gate);
        cyc(20);
        rdc(`GPT_B0_COUNT_OFF, 32'h0);
        gate_in <= 3'b010;
        cyc(20);
        gate_in <= 3'b000;
        cyc(5);
        rd(`GPT_B0_COUNT_OFF, r);
        chk_rng(r, 16, 24);
        wr(`GPT_B0_CTRL_OFF, k_on | k_gate | k_cs);
        wr(`GPT_B0_COUNT_OFF, 32'h0);
        e0 = edges;
        slow <= 1'b1;
        pulses(5);
        wr(`GPT_B0_CTRL_OFF, 32'h0);
        rdc(`GPT_B0_COUNT_OFF, 32'(edges - e0));
        wr(`GPT_B1_COUNT_OFF, 32'h0);
        wr(`GPT_B0_COUNT_OFF, 32'hfffc);
        wr(`GPT_B0_CTRL_OFF, k_on | k_join);
        cyc(10);
        wr(`GPT_B0_CTRL_OFF, 32'h0);
        rdc(`GPT_B1_COUNT_OFF, 32'h1);
        rd(`GPT_B0_COUNT_OFF, r);
        chk_rng(r, 4, 14);
    endtask : t_gate_join
    task automatic t_async();
        int e0;
        wr(`GPT_A_PERIOD_OFF, 32'hffff);
        wr(`GPT_A_CTRL_OFF, k_on | k_cs | k_idle);
        wr(`GPT_A_COUNT_OFF, 32'h0);
        idle_in <= 1'b1;
        slow <= 1'b0;
        e0 = edges;
        pulses(6);
        idle_in <= 1'b0;
        wr(`GPT_A_CTRL_OFF, 32'h0);
        rdc(`GPT_A_COUNT_OFF, 32'(edges - e0));
    endtask : t_async
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    // Main sequence after reset
    initial begin
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        t_regs();
        t_prescale();
        t_wrap();
        t_gate_join();
        t_async();
        stop_test();
    end
    // Watchdog, several times the expected run length
    initial begin
        repeat (40000) @(posedge clk_in);
        bad_count++;
        stop_test();
    end
endmodule : tb_top
